// >>> rtl/aif_pkg.sv
// Shared constants, modes and states for the accelerometer and inclinometer output formatter
package aif_pkg;

    // Word and datapath widths
    localparam int WORD_W         = 24;
    localparam int BYTE_W         = 8;
    localparam int RAW_W          = 28;
    localparam int SUM_W          = 32;
    localparam int CNT_W          = 8;
    localparam int INT_W          = 30;
    localparam int SHIFT_W        = 3;
    localparam int STEP_W         = 5;
    localparam int BYTES_PER_WORD = 3;
    localparam int FIFO_DEPTH     = 8;

    // Divider runs one quotient bit per cycle
    localparam logic [STEP_W-1:0] DIV_LAST_STEP = 5'h1F;
    localparam logic [1:0]        LAST_BYTE_IDX = 2'h2;
    localparam logic [CNT_W-1:0]  CNT_MAX       = 8'hFF;

    // Raw acceleration arrives at 2^20 counts per g
    localparam logic [SHIFT_W-1:0] ACC_SHIFT_5G  = 3'h0;
    localparam logic [SHIFT_W-1:0] ACC_SHIFT_10G = 3'h1;
    localparam logic [SHIFT_W-1:0] ACC_SHIFT_30G = 3'h2;
    localparam logic [SHIFT_W-1:0] ACC_SHIFT_80G = 3'h4;

    // Raw velocity increment arrives at 2^25 counts per m/s
    localparam logic [SHIFT_W-1:0] IV_SHIFT_5G   = 3'h2;
    localparam logic [SHIFT_W-1:0] IV_SHIFT_10G  = 3'h3;
    localparam logic [SHIFT_W-1:0] IV_SHIFT_30G  = 3'h4;
    localparam logic [SHIFT_W-1:0] IV_SHIFT_80G  = 3'h6;

    // Values after reset
    localparam logic [WORD_W-1:0] WORD_RESET = 24'h000000;
    localparam logic [SUM_W-1:0]  SUM_RESET  = 32'h00000000;
    localparam logic [INT_W-1:0]  INT_RESET  = 30'h00000000;
    localparam logic [CNT_W-1:0]  CNT_RESET  = 8'h00;

    typedef enum logic [1:0]
    {
        RANGE_5G  = 2'h0,
        RANGE_10G = 2'h1,
        RANGE_30G = 2'h2,
        RANGE_80G = 2'h3
    } aif_range_t;

    typedef enum logic [1:0]
    {
        UNIT_ACCEL     = 2'h0,
        UNIT_INCR_VEL  = 2'h1,
        UNIT_AVG_ACCEL = 2'h2,
        UNIT_INT_VEL   = 2'h3
    } aif_unit_t;

    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_DIV,
        ST_DIV_DONE,
        ST_PUSH_ACC,
        ST_PUSH_INCL
    } aif_state_t;

endpackage : aif_pkg

// >>> rtl/aif_fifo.sv
// Word FIFO with valid and ready on both sides
`timescale 1ns/1ps
module aif_fifo
    import aif_pkg::*;
#(
    parameter int WIDTH = WORD_W,
    parameter int DEPTH = FIFO_DEPTH
)
(
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // Fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W2 = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0]  PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W2-1:0] CNT_FULL = CNT_W2'(DEPTH);

    logic [WIDTH-1:0]  mem [DEPTH];
    logic [PTR_W-1:0]  wr_ptr;
    logic [PTR_W-1:0]  rd_ptr;
    logic [CNT_W2-1:0] fill;
    logic [PTR_W-1:0]  next_wr_ptr;
    logic [PTR_W-1:0]  next_rd_ptr;
    logic [CNT_W2-1:0] next_fill;
    logic              push;
    logic              pop;

    assign in_ready_out  = (fill != CNT_FULL);
    assign out_valid_out = (fill != '0);
    assign out_data_out  = mem[rd_ptr];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_comb
    begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_fill   = fill;
        if (push)
        begin
            next_wr_ptr = (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
        end
        if (pop)
        begin
            next_rd_ptr = (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
        end
        if (push && !pop)
        begin
            next_fill = fill + 1'b1;
        end
        else if (pop && !push)
        begin
            next_fill = fill - 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            fill   <= next_fill;
        end
    end

    // Storage needs no reset; empty flag guards reads
    always_ff @(posedge clk_in)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data_in;
        end
    end

endmodule : aif_fifo

// >>> rtl/aif_formatter.sv
// Accelerometer and inclinometer output word formatter with byte serialiser
`timescale 1ns/1ps
module aif_formatter
    import aif_pkg::*;
(
    // Clock and reset
    input  wire logic                mclk_in,
    input  wire logic                resetn_in,
    // Configuration
    input  wire logic [1:0]          range_in,
    input  wire logic [1:0]          unit_in,
    // Internal samples
    input  wire logic                sample_valid_in,
    input  wire logic [RAW_W-1:0]    accel_sample_in,
    input  wire logic [RAW_W-1:0]    incr_sample_in,
    input  wire logic [WORD_W-1:0]   incl_sample_in,
    // Transmission request
    input  wire logic                xmit_in,
    output logic                     busy_out,
    // Byte stream
    output logic [BYTE_W-1:0]        byte_out,
    output logic                     byte_valid_out,
    output logic                     byte_last_out,
    input  wire logic                byte_ready_in
);
    logic [1:0] rst_sync;
    logic       rst_n;

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rst_sync <= 2'h0;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    function automatic logic [SHIFT_W-1:0] acc_shift(input logic [1:0] rng);
        unique case (aif_range_t'(rng))
            RANGE_5G:  acc_shift = ACC_SHIFT_5G;
            RANGE_10G: acc_shift = ACC_SHIFT_10G;
            RANGE_30G: acc_shift = ACC_SHIFT_30G;
            RANGE_80G: acc_shift = ACC_SHIFT_80G;
        endcase
    endfunction : acc_shift

    function automatic logic [SHIFT_W-1:0] iv_shift(input logic [1:0] rng);
        unique case (aif_range_t'(rng))
            RANGE_5G:  iv_shift = IV_SHIFT_5G;
            RANGE_10G: iv_shift = IV_SHIFT_10G;
            RANGE_30G: iv_shift = IV_SHIFT_30G;
            RANGE_80G: iv_shift = IV_SHIFT_80G;
        endcase
    endfunction : iv_shift

    // Out-of-range samples clip instead of folding over
    function automatic logic [WORD_W-1:0] scale_sat(input logic [RAW_W-1:0] raw, input logic [SHIFT_W-1:0] sh);
        logic signed [RAW_W-1:0] s;
        s = $signed(raw) >>> sh;
        if (s > 28'sh07FFFFF)
        begin
            scale_sat = 24'h7FFFFF;
        end
        else if (s < 28'shF800000)
        begin
            scale_sat = 24'h800000;
        end
        else
        begin
            scale_sat = s[WORD_W-1:0];
        end
    endfunction : scale_sat

    // Sample group
    logic [WORD_W-1:0]        acc_word;
    logic [WORD_W-1:0]        incr_word;
    logic [WORD_W-1:0]        incl_word;
    logic signed [INT_W-1:0]  int_acc;
    logic signed [SUM_W-1:0]  avg_sum;
    logic [CNT_W-1:0]         avg_cnt;
    logic [WORD_W-1:0]        next_acc_word;
    logic [WORD_W-1:0]        next_incr_word;
    logic [WORD_W-1:0]        next_incl_word;
    logic signed [INT_W-1:0]  next_int_acc;
    logic signed [SUM_W-1:0]  next_avg_sum;
    logic [CNT_W-1:0]         next_avg_cnt;
    logic [WORD_W-1:0]        sample_acc;
    logic signed [INT_W-1:0]  int_shifted;
    logic [WORD_W-1:0]        int_word;
    logic                     take;

    // State group
    aif_state_t               state;
    aif_state_t               next_state;
    logic [SUM_W-1:0]         quot;
    logic [CNT_W-1:0]         rem;
    logic [CNT_W-1:0]         divisor;
    logic [STEP_W-1:0]        step;
    logic                     neg;
    logic [WORD_W-1:0]        out_word;
    logic [WORD_W-1:0]        incl_snap;
    logic [SUM_W-1:0]         next_quot;
    logic [CNT_W-1:0]         next_rem;
    logic [CNT_W-1:0]         next_divisor;
    logic [STEP_W-1:0]        next_step;
    logic                     next_neg;
    logic [WORD_W-1:0]        next_out_word;
    logic [WORD_W-1:0]        next_incl_snap;
    logic [CNT_W:0]           trial;
    logic [WORD_W-1:0]        quot_mag;

    // FIFO and serialiser
    logic                     fifo_in_valid;
    logic                     fifo_in_ready;
    logic [WORD_W-1:0]        fifo_in_data;
    logic                     fifo_out_valid;
    logic                     fifo_out_ready;
    logic [WORD_W-1:0]        fifo_out_data;
    logic [WORD_W-1:0]        ser_word;
    logic                     ser_full;
    logic [1:0]               ser_idx;
    logic [WORD_W-1:0]        next_ser_word;
    logic                     next_ser_full;
    logic [1:0]               next_ser_idx;

    assign take        = (state == ST_IDLE) && xmit_in;
    assign sample_acc  = scale_sat(accel_sample_in, acc_shift(range_in));
    assign int_shifted = int_acc >>> iv_shift(range_in);
    assign int_word    = int_shifted[WORD_W-1:0];

    always_comb
    begin
        next_acc_word  = acc_word;
        next_incr_word = incr_word;
        next_incl_word = incl_word;
        next_int_acc   = int_acc;
        next_avg_sum   = avg_sum;
        next_avg_cnt   = avg_cnt;
        if (sample_valid_in)
        begin
            next_acc_word  = sample_acc;
            next_incr_word = scale_sat(incr_sample_in, iv_shift(range_in));
            next_incl_word = incl_sample_in;
            // Wide sum wraps mod 2^30, so the sent window wraps on its own
            next_int_acc   = int_acc + INT_W'($signed(incr_sample_in));
        end
        if (take)
        begin
            // A sample in the take cycle opens the new average
            next_avg_sum = sample_valid_in ? SUM_W'($signed(sample_acc)) : SUM_RESET;
            next_avg_cnt = sample_valid_in ? 8'h01 : CNT_RESET;
        end
        else if (sample_valid_in && (avg_cnt != CNT_MAX))
        begin
            // Past 255 samples the mean holds only the first 255
            next_avg_sum = avg_sum + SUM_W'($signed(sample_acc));
            next_avg_cnt = avg_cnt + 1'b1;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_word  <= WORD_RESET;
            incr_word <= WORD_RESET;
            incl_word <= WORD_RESET;
            int_acc   <= INT_RESET;
            avg_sum   <= SUM_RESET;
            avg_cnt   <= CNT_RESET;
        end
        else
        begin
            acc_word  <= next_acc_word;
            incr_word <= next_incr_word;
            incl_word <= next_incl_word;
            int_acc   <= next_int_acc;
            avg_sum   <= next_avg_sum;
            avg_cnt   <= next_avg_cnt;
        end
    end

    assign trial    = {rem, quot[SUM_W-1]} - {1'b0, divisor};
    assign quot_mag = quot[WORD_W-1:0];

    always_comb
    begin
        next_state     = state;
        next_quot      = quot;
        next_rem       = rem;
        next_divisor   = divisor;
        next_step      = step;
        next_neg       = neg;
        next_out_word  = out_word;
        next_incl_snap = incl_snap;
        fifo_in_valid  = 1'b0;
        fifo_in_data   = out_word;
        unique case (state)
            ST_IDLE:
            begin
                if (xmit_in)
                begin
                    next_incl_snap = incl_word;
                    next_state     = ST_PUSH_ACC;
                    unique case (aif_unit_t'(unit_in))
                        UNIT_ACCEL:    next_out_word = acc_word;
                        UNIT_INCR_VEL: next_out_word = incr_word;
                        UNIT_INT_VEL:  next_out_word = int_word;
                        UNIT_AVG_ACCEL:
                        begin
                            if (avg_cnt == CNT_RESET)
                            begin
                                next_out_word = WORD_RESET;
                            end
                            else
                            begin
                                // Divide magnitudes, restore sign after
                                next_neg     = avg_sum[SUM_W-1];
                                next_quot    = avg_sum[SUM_W-1] ? SUM_W'(-avg_sum) : avg_sum;
                                next_rem     = CNT_RESET;
                                next_divisor = avg_cnt;
                                next_step    = '0;
                                next_state   = ST_DIV;
                            end
                        end
                    endcase
                end
            end
            ST_DIV:
            begin
                if (!trial[CNT_W])
                begin
                    next_rem  = trial[CNT_W-1:0];
                    next_quot = {quot[SUM_W-2:0], 1'b1};
                end
                else
                begin
                    next_rem  = {rem[CNT_W-2:0], quot[SUM_W-1]};
                    next_quot = {quot[SUM_W-2:0], 1'b0};
                end
                next_step = step + 1'b1;
                if (step == DIV_LAST_STEP)
                begin
                    next_state = ST_DIV_DONE;
                end
            end
            ST_DIV_DONE:
            begin
                // Mean of saturated words always fits the word
                next_out_word = neg ? WORD_W'(-quot_mag) : quot_mag;
                next_state    = ST_PUSH_ACC;
            end
            ST_PUSH_ACC:
            begin
                fifo_in_valid = 1'b1;
                fifo_in_data  = out_word;
                if (fifo_in_ready)
                begin
                    next_state = ST_PUSH_INCL;
                end
            end
            ST_PUSH_INCL:
            begin
                fifo_in_valid = 1'b1;
                fifo_in_data  = incl_snap;
                if (fifo_in_ready)
                begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state     <= ST_IDLE;
            quot      <= SUM_RESET;
            rem       <= CNT_RESET;
            divisor   <= CNT_RESET;
            step      <= '0;
            neg       <= 1'b0;
            out_word  <= WORD_RESET;
            incl_snap <= WORD_RESET;
        end
        else
        begin
            state     <= next_state;
            quot      <= next_quot;
            rem       <= next_rem;
            divisor   <= next_divisor;
            step      <= next_step;
            neg       <= next_neg;
            out_word  <= next_out_word;
            incl_snap <= next_incl_snap;
        end
    end

    assign busy_out = (state != ST_IDLE);

    aif_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (mclk_in),
        .rst_n_in      (rst_n),
        .in_valid_in   (fifo_in_valid),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (fifo_in_data),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (fifo_out_ready),
        .out_data_out  (fifo_out_data)
    );

    assign byte_out       = ser_word[WORD_W-1 -: BYTE_W];
    assign byte_valid_out = ser_full;
    assign byte_last_out  = ser_full && (ser_idx == LAST_BYTE_IDX);
    assign fifo_out_ready = !ser_full || (byte_ready_in && byte_last_out);

    always_comb
    begin
        next_ser_word = ser_word;
        next_ser_full = ser_full;
        next_ser_idx  = ser_idx;
        if (ser_full && byte_ready_in)
        begin
            next_ser_word = {ser_word[WORD_W-BYTE_W-1:0], {BYTE_W{1'b0}}};
            next_ser_idx  = ser_idx + 1'b1;
            if (byte_last_out)
            begin
                next_ser_full = 1'b0;
            end
        end
        if (fifo_out_valid && fifo_out_ready)
        begin
            next_ser_word = fifo_out_data;
            next_ser_full = 1'b1;
            next_ser_idx  = 2'h0;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ser_word <= WORD_RESET;
            ser_full <= 1'b0;
            ser_idx  <= 2'h0;
        end
        else
        begin
            ser_word <= next_ser_word;
            ser_full <= next_ser_full;
            ser_idx  <= next_ser_idx;
        end
    end

endmodule : aif_formatter

// >>> verification/aif_formatter_props.sv
// Port-level assertions for the output formatter
`timescale 1ns/1ps
module aif_formatter_props
    import aif_pkg::*;
(
    // Clock and reset
    input  wire logic              mclk_in,
    input  wire logic              resetn_in,
    // Transmission control
    input  wire logic [1:0]        unit_in,
    input  wire logic              xmit_in,
    input  wire logic              busy_out,
    // Byte stream
    input  wire logic [BYTE_W-1:0] byte_out,
    input  wire logic              byte_valid_out,
    input  wire logic              byte_last_out,
    input  wire logic              byte_ready_in
);
    logic [1:0] idx;
    logic [1:0] next_idx;

    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (!resetn_in);

    // Position of the next byte within its word
    always_comb
    begin
        next_idx = idx;
        if (byte_valid_out && byte_ready_in)
            next_idx = (idx == 2'h2) ? 2'h0 : idx + 2'h1;
    end

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            idx <= 2'h0;
        else
            idx <= next_idx;
    end

    property p_last_third;
        byte_valid_out |-> (byte_last_out == (idx == 2'h2));
    endproperty
    a_last_third: assert property (p_last_third)
        else $error("last flag not on third byte");

    property p_hold;
        byte_valid_out && !byte_ready_in |=> byte_valid_out && $stable(byte_out) && $stable(byte_last_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("byte changed while stalled");

    property p_last_valid;
        byte_last_out |-> byte_valid_out;
    endproperty
    a_last_valid: assert property (p_last_valid)
        else $error("last flag without valid");

    property p_valid_cause;
        $rose(byte_valid_out) |-> $past(busy_out);
    endproperty
    a_valid_cause: assert property (p_valid_cause)
        else $error("bytes without a transmission");

    property p_idle;
        !busy_out && !byte_valid_out && !xmit_in |=> !byte_valid_out;
    endproperty
    a_idle: assert property (p_idle)
        else $error("bytes appeared while idle");

    property p_fast;
        xmit_in && !busy_out && unit_in != 2'h2 && !byte_valid_out |=> busy_out ##1 busy_out ##1 !busy_out;
    endproperty
    a_fast: assert property (p_fast)
        else $error("direct transmission timing wrong");

    property p_avg;
        xmit_in && !busy_out && unit_in == 2'h2 && !byte_valid_out |=> busy_out[*2] ##[1:34] !busy_out;
    endproperty
    a_avg: assert property (p_avg)
        else $error("average transmission timing wrong");

    property p_reset;
        disable iff (1'b0) !resetn_in |-> !busy_out && !byte_valid_out;
    endproperty
    a_reset: assert property (p_reset)
        else $error("outputs active in reset");
endmodule : aif_formatter_props

bind aif_formatter aif_formatter_props i_props
(
    .mclk_in        (mclk_in),
    .resetn_in      (resetn_in),
    .unit_in        (unit_in),
    .xmit_in        (xmit_in),
    .busy_out       (busy_out),
    .byte_out       (byte_out),
    .byte_valid_out (byte_valid_out),
    .byte_last_out  (byte_last_out),
    .byte_ready_in  (byte_ready_in)
);

// >>> verification/aif_host_model.sv
// Host byte sink that rebuilds output words
`timescale 1ns/1ps
module aif_host_model
    import aif_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              slow_in,
    input  wire logic [BYTE_W-1:0] byte_in,
    input  wire logic              valid_in,
    input  wire logic              last_in,
    output logic                   ready_out
);
    logic [WORD_W-1:0] words[$];
    logic [WORD_W-1:0] acc = '0;
    int                nbytes = 0;
    int                frame_err = 0;

    initial
        ready_out = 1'b1;

    always @(posedge clk_in)
    begin
        if (valid_in && ready_out)
        begin
            acc = {acc[15:0], byte_in};
            nbytes++;
            if (last_in !== (nbytes == 3))
                frame_err++;
            if (nbytes == 3)
            begin
                words.push_back(acc);
                nbytes = 0;
            end
        end
        // Slow mode stalls every other cycle
        ready_out <= #1 (slow_in ? ~ready_out : 1'b1);
    end
endmodule : aif_host_model

// >>> verification/aif_formatter_tb.sv
// Self-checking bench for the output formatter
`timescale 1ns/1ps
module aif_formatter_tb;
    import aif_pkg::*;
    logic              mclk_in = 1'b0;
    // Starts high so the drop at time zero is a real edge for the async reset
    logic              resetn_in = 1'b1;
    logic [1:0]        range_in = 2'h0;
    logic [1:0]        unit_in = 2'h0;
    logic              sample_valid_in = 1'b0;
    logic [RAW_W-1:0]  accel_sample_in = '0;
    logic [RAW_W-1:0]  incr_sample_in = '0;
    logic [WORD_W-1:0] incl_sample_in = '0;
    logic              xmit_in = 1'b0;
    logic              busy_out;
    logic [BYTE_W-1:0] byte_out;
    logic              byte_valid_out;
    logic              byte_last_out;
    logic              byte_ready_in;
    logic              slow = 1'b0;
    logic [INT_W-1:0]  int_sum;
    logic [WORD_W-1:0] got_w;
    logic [WORD_W-1:0] got_c;
    int                err_total = 0;
    int                checked = 0;
    int                k_iv[4] = '{23, 22, 21, 19};
    int                k_acc[4] = '{20, 19, 18, 16};

    always #5 mclk_in = ~mclk_in;

    aif_formatter i_dut
    (
        .mclk_in         (mclk_in),
        .resetn_in       (resetn_in),
        .range_in        (range_in),
        .unit_in         (unit_in),
        .sample_valid_in (sample_valid_in),
        .accel_sample_in (accel_sample_in),
        .incr_sample_in  (incr_sample_in),
        .incl_sample_in  (incl_sample_in),
        .xmit_in         (xmit_in),
        .busy_out        (busy_out),
        .byte_out        (byte_out),
        .byte_valid_out  (byte_valid_out),
        .byte_last_out   (byte_last_out),
        .byte_ready_in   (byte_ready_in)
    );

    aif_host_model i_host
    (
        .clk_in    (mclk_in),
        .slow_in   (slow),
        .byte_in   (byte_out),
        .valid_in  (byte_valid_out),
        .last_in   (byte_last_out),
        .ready_out (byte_ready_in)
    );

    task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask : tick

    task automatic do_reset;
        resetn_in = 1'b0;
        tick(4);
        resetn_in = 1'b1;
        int_sum = '0;
        tick(3);
    endtask : do_reset

    task automatic sample(input logic [RAW_W-1:0] a, input logic [RAW_W-1:0] v);
        accel_sample_in = a;
        incr_sample_in = v;
        sample_valid_in = 1'b1;
        int_sum = int_sum + INT_W'($signed(v));
        tick(1);
        sample_valid_in = 1'b0;
        tick(1);
    endtask : sample

    // Request held two extra cycles while busy, which must be ignored
    task automatic xfer(input logic [1:0] u);
        int n;
        n = 0;
        unit_in = u;
        xmit_in = 1'b1;
        tick(3);
        xmit_in = 1'b0;
        while (i_host.words.size() < 2 && n < 500)
        begin
            tick(1);
            n++;
        end
        if (n == 500)
        begin
            err_total++;
            $display("mismatch at %0t: words missing", $time);
            final_report();
        end
        else
        begin
            got_w = i_host.words.pop_front();
            got_c = i_host.words.pop_front();
        end
    endtask : xfer

    task automatic s_incr;
        for (int r = 0; r < 4; r++)
        begin
            range_in = 2'(r);
            slow = r[0];
            incl_sample_in = 24'h800001 ^ 24'(r);
            sample(28'h0, 28'h1000000);
            xfer(UNIT_INCR_VEL);
            check(got_w, 24'h1 << (k_iv[r] - 1));
            check(got_c, incl_sample_in);
            sample(28'h0, 28'hF000000);
            xfer(UNIT_INCR_VEL);
            check(got_w, -(24'h1 << (k_iv[r] - 1)));
            sample(28'h0100000, 28'h0);
            xfer(UNIT_ACCEL);
            check(got_w, 24'h1 << k_acc[r]);
        end
        range_in = RANGE_10G;
        sample(28'h0, 28'hC000000);
        xfer(UNIT_INCR_VEL);
        check(got_w, 24'h800000);
    endtask : s_incr

    task automatic s_avg;
        range_in = RANGE_10G;
        xfer(UNIT_AVG_ACCEL);
        sample(28'h0100000, 28'h0);
        sample(28'h0200000, 28'h0);
        sample(28'h0300000, 28'h0);
        xfer(UNIT_AVG_ACCEL);
        check(got_w, 24'h100000);
        sample(28'hFF00000, 28'h0);
        xfer(UNIT_AVG_ACCEL);
        check(got_w, 24'hF80000);
        xfer(UNIT_AVG_ACCEL);
        check(got_w, WORD_RESET);
    endtask : s_avg

    task automatic s_int;
        repeat (5) sample(28'h0, 28'h1000000);
        for (int r = 0; r < 4; r++)
        begin
            range_in = 2'(r);
            xfer(UNIT_INT_VEL);
            check(got_w, int_sum[25 - k_iv[r] +: 24]);
        end
        do_reset();
        range_in = RANGE_5G;
        sample(28'h0, 28'h0ABCDE0);
        xfer(UNIT_INT_VEL);
        check(got_w, 24'h2AF378);
        // Sum passes +1 m/s at 5g, so the word must fold to the negative end
        sample(28'h0, 28'h6000000);
        xfer(UNIT_INT_VEL);
        check(got_w, 24'hAAF378);
    endtask : s_int

    initial
    begin
        do_reset();
        s_incr();
        s_avg();
        s_int();
        tick(60);
        check(WORD_W'(i_host.words.size()), '0);
        check(WORD_W'(i_host.frame_err), '0);
        final_report();
    end
endmodule : aif_formatter_tb
